//--- sbwd_pkg.sv
// Package of constants for the SRAM byte-write decode
package sbwd_pkg;
  localparam int unsigned LANES      = 4;
  localparam int unsigned LANE_DATA  = 8;
  localparam int unsigned LANE_WIDTH = LANE_DATA + 1;
  localparam int unsigned WORD_WIDTH = LANES * LANE_WIDTH;
  localparam int unsigned PARITY_POS = 8;
  localparam logic [3:0]  LANES_NONE = 4'h0;
  localparam logic [3:0]  LANES_ALL  = 4'hF;
  localparam logic [3:0]  EN_N_IDLE  = 4'hF;
  localparam int unsigned ADDR_WIDTH = 4;
  typedef enum logic [1:0] {
    SBWD_IDLE,
    SBWD_READ,
    SBWD_WRITE
  } sbwd_cycle_t;
endpackage

//--- sbwd_lane.sv
// One byte lane of storage: eight data bits plus parity
`timescale 1ns/1ps
`default_nettype none
module sbwd_lane #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4,
  parameter int unsigned W     = 9
) (
  input  wire logic          mclk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [W-1:0]  wdata_i,
  output logic      [W-1:0]  rdata_o
);
  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d;

  always_comb begin
    mem_d = mem_q[addr_i];
    if (we_i) begin
      mem_d = wdata_i;
    end
  end

  // Storage carries no reset, as with the array of a real SRAM
  always_ff @(posedge mclk_i) begin
    mem_q[addr_i] <= mem_d;
  end

  assign rdata_o = mem_q[addr_i];
endmodule
`default_nettype wire

//--- sbwd_top.sv
// Byte-write decode and four-lane storage of a pipelined synchronous SRAM with registered output data
// Function
// - Strobe high, master or all lanes high: read
// - Lane low, master low, strobe high: write lane
// - All sixteen lane enable combinations are legal
// - Only enabled lanes change; others keep contents
// - Global strobe low writes all four lanes
// - Write when strobe low or master plus lane
// - Address strobe always starts a read
// - Data pins released once a write is seen
`timescale 1ns/1ps
`default_nettype none
module sbwd_top #(
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                                mclk_i,
  input  wire logic                                reset_i,
  input  wire logic [sbwd_pkg::ADDR_WIDTH-1:0]     addr_i,
  input  wire logic                                processor_addr_strobe_n_i,
  input  wire logic                                global_write_n_i,
  input  wire logic                                byte_write_master_en_n_i,
  input  wire logic                                lane0_write_en_n_i,
  input  wire logic                                lane1_write_en_n_i,
  input  wire logic                                lane2_write_en_n_i,
  input  wire logic                                lane3_write_en_n_i,
  input  wire logic                                output_en_n_i,
  input  wire logic [sbwd_pkg::WORD_WIDTH-1:0]     dq_i,
  output logic      [sbwd_pkg::WORD_WIDTH-1:0]     dq_o,
  output logic                                     dq_oe_n_o,
  output logic                                     write_cycle_o,
  output logic      [sbwd_pkg::LANES-1:0]          lanes_written_o
);
  // Pins from the processor pass two flip-flops before the decode reads them
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [sbwd_pkg::ADDR_WIDTH-1:0] addr_q;
  logic [sbwd_pkg::WORD_WIDTH-1:0] din_q;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= 8'hFF;
      sync2_q <= 8'hFF;
    end else begin
      sync1_q <= {output_en_n_i, processor_addr_strobe_n_i, global_write_n_i,
                  byte_write_master_en_n_i, lane3_write_en_n_i, lane2_write_en_n_i,
                  lane1_write_en_n_i, lane0_write_en_n_i};
      sync2_q <= sync1_q;
    end
  end

  // Address and data are delayed to stay aligned with the synchronised controls
  logic [sbwd_pkg::ADDR_WIDTH-1:0] addr1_q;
  logic [sbwd_pkg::WORD_WIDTH-1:0] din1_q;
  always_ff @(posedge mclk_i) begin
    addr1_q <= addr_i;
    addr_q  <= addr1_q;
    din1_q  <= dq_i;
    din_q   <= din1_q;
  end

  logic       oe_n_s;
  logic       ads_n_s;
  logic       gw_n_s;
  logic       bwe_n_s;
  logic [3:0] lane_n_s;
  assign oe_n_s   = sync2_q[7];
  assign ads_n_s  = sync2_q[6];
  assign gw_n_s   = sync2_q[5];
  assign bwe_n_s  = sync2_q[4];
  assign lane_n_s = sync2_q[3:0];

  // Decode is a pure function of the sampled strobes
  logic [3:0] lane_we;
  logic       write_ind;
  always_comb begin
    lane_we   = sbwd_pkg::LANES_NONE;
    write_ind = 1'b0;
    if (!ads_n_s) begin
      lane_we = sbwd_pkg::LANES_NONE;
    end else if (!gw_n_s) begin
      lane_we = sbwd_pkg::LANES_ALL;
    end else if (!bwe_n_s) begin
      lane_we = ~lane_n_s;
    end
    write_ind = ads_n_s && (!gw_n_s || (!bwe_n_s && (lane_n_s != sbwd_pkg::EN_N_IDLE)));
  end

  // Lane order and parity placement within each nine-bit slice
  logic [sbwd_pkg::WORD_WIDTH-1:0] rword;
  genvar g;
  generate
    for (g = 0; g < sbwd_pkg::LANES; g++) begin : g_lane
      sbwd_lane #(
        .DEPTH (DEPTH),
        .AW    (sbwd_pkg::ADDR_WIDTH),
        .W     (sbwd_pkg::LANE_WIDTH)
      ) u_lane (
        .mclk_i  (mclk_i),
        .we_i    (lane_we[g]),
        .addr_i  (addr_q),
        .wdata_i (din_q[g*sbwd_pkg::LANE_WIDTH +: sbwd_pkg::LANE_WIDTH]),
        .rdata_o (rword[g*sbwd_pkg::LANE_WIDTH +: sbwd_pkg::LANE_WIDTH])
      );
    end
  endgenerate

  // Output stage: registered data, enable released on any write
  logic [sbwd_pkg::WORD_WIDTH-1:0] dq_q;
  logic [sbwd_pkg::WORD_WIDTH-1:0] dq_d;
  logic                            oe_n_q;
  logic                            oe_n_d;
  logic                            wr_q;
  logic                            wr_d;
  logic [3:0]                      lw_q;
  logic [3:0]                      lw_d;

  always_comb begin
    dq_d   = dq_q;
    wr_d   = write_ind;
    lw_d   = lane_we;
    oe_n_d = 1'b1;
    if (!write_ind) begin
      dq_d   = rword;
      oe_n_d = oe_n_s;
    end else begin
      oe_n_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      dq_q   <= '0;
      oe_n_q <= 1'b1;
      wr_q   <= 1'b0;
      lw_q   <= sbwd_pkg::LANES_NONE;
    end else begin
      dq_q   <= dq_d;
      oe_n_q <= oe_n_d;
      wr_q   <= wr_d;
      lw_q   <= lw_d;
    end
  end

  assign dq_o            = dq_q;
  assign dq_oe_n_o       = oe_n_q;
  assign write_cycle_o   = wr_q;
  assign lanes_written_o = lw_q;

  // Checks
  property p_read_no_lanes;
    @(posedge mclk_i) disable iff (reset_i)
      (gw_n_s && (bwe_n_s || lane_n_s == sbwd_pkg::EN_N_IDLE)) |=> (lw_q == 4'h0 && !wr_q);
  endproperty
  a_read_no_lanes: assert property (p_read_no_lanes) else $error("read wrote a lane");

  property p_lane_write;
    @(posedge mclk_i) disable iff (reset_i)
      (ads_n_s && gw_n_s && !bwe_n_s) |=> (lw_q == ~$past(lane_n_s));
  endproperty
  a_lane_write: assert property (p_lane_write) else $error("lane mask mismatch");

  property p_any_combo;
    @(posedge mclk_i) disable iff (reset_i)
      (ads_n_s && gw_n_s && !bwe_n_s && lane_n_s != 4'hF) |=> wr_q;
  endproperty
  a_any_combo: assert property (p_any_combo) else $error("combination refused");

  property p_keep_lanes;
    @(posedge mclk_i) disable iff (reset_i)
      (wr_q && $past(ads_n_s && gw_n_s)) |-> ((lw_q & $past(lane_n_s)) == 4'h0);
  endproperty
  a_keep_lanes: assert property (p_keep_lanes) else $error("extra lane written");

  property p_global_all;
    @(posedge mclk_i) disable iff (reset_i)
      (ads_n_s && !gw_n_s) |=> (lw_q == 4'hF);
  endproperty
  a_global_all: assert property (p_global_all) else $error("global write not full");

  property p_write_ind;
    @(posedge mclk_i) disable iff (reset_i)
      1'b1 |=> (wr_q == $past(ads_n_s && (!gw_n_s || (!bwe_n_s && !(&lane_n_s))))
                && wr_q == (lw_q != 4'h0));
  endproperty
  a_write_ind: assert property (p_write_ind) else $error("write indication wrong");

  property p_strobe_read;
    @(posedge mclk_i) disable iff (reset_i)
      !ads_n_s |=> (!wr_q && lw_q == 4'h0);
  endproperty
  a_strobe_read: assert property (p_strobe_read) else $error("write on strobe edge");

  sequence s_write_seen;
    write_ind;
  endsequence
  property p_hiz_write;
    @(posedge mclk_i) disable iff (reset_i)
      s_write_seen |=> dq_oe_n_o;
  endproperty
  a_hiz_write: assert property (p_hiz_write) else $error("pins driven in write");
endmodule
`default_nettype wire

//--- sbwd_cpu_model.sv
// Processor-side model driving the SRAM control and data pins
`timescale 1ns/1ps
`default_nettype none
module sbwd_cpu_model (
  input  wire logic        mclk_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic [39:0] ad_i,
  output logic      [7:0]  pins_o,
  output logic      [39:0] ad_o
);
  // Idle pins from time zero so the SRAM never samples unknown controls
  initial begin
    pins_o = 8'hFF;
    ad_o = 40'h00_0000_0000;
  end
  // Pins move 1 ns after the edge, giving the SRAM 24 ns of setup in a 25 ns cycle
  always @(posedge mclk_i) begin
    pins_o <= #1 cmd_i;
    ad_o <= #1 ad_i;
  end
endmodule
`default_nettype wire

//--- test_sram_byte_write_decode.sv
// Self-checking bench for the SRAM byte-write decode
`timescale 1ns/1ps
`default_nettype none
module test_sram_byte_write_decode;
  logic        mclk_i, reset_i, oe_n, wr;
  logic [7:0]  cmd, pins;
  logic [39:0] ad, adp;
  logic [35:0] dq;
  logic [3:0]  lw, m;
  // Rows: strobe, master, lane enables (3..0), expected written lanes
  logic [9:0]  rows [18] = '{10'h20F, 10'h21E, 10'h22D, 10'h23C, 10'h24B, 10'h25A,
                             10'h269, 10'h278, 10'h287, 10'h296, 10'h2A5, 10'h2B4,
                             10'h2C3, 10'h2D2, 10'h2E1, 10'h2F0, 10'h300, 10'h1FF};
  int          error_cnt, num_checks;
  sbwd_cpu_model i_cpu (.mclk_i(mclk_i), .cmd_i(cmd), .ad_i(ad), .pins_o(pins), .ad_o(adp));
  sbwd_top i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(adp[39:36]),
    .processor_addr_strobe_n_i(pins[7]), .global_write_n_i(pins[6]),
    .byte_write_master_en_n_i(pins[5]), .lane0_write_en_n_i(pins[1]),
    .lane1_write_en_n_i(pins[2]), .lane2_write_en_n_i(pins[3]),
    .lane3_write_en_n_i(pins[4]), .output_en_n_i(pins[0]), .dq_i(adp[35:0]),
    .dq_o(dq), .dq_oe_n_o(oe_n), .write_cycle_o(wr), .lanes_written_o(lw));
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  function automatic logic [35:0] spread(input logic [3:0] mk);
    logic [35:0] v;
    for (int g = 0; g < 4; g++) v[9*g+:9] = {9{mk[g]}};
    return v;
  endfunction
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
    num_checks++;
    if (e !== s) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Holds one cycle's pins until its decode result has settled
  task automatic op(input logic [7:0] c, input logic [3:0] a, input logic [35:0] d);
    cmd = c;
    ad = {a, d};
    repeat (5) @(posedge mclk_i);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    stop_test();
  end
  initial begin
    reset_i = 1'b1;
    cmd = 8'hFF;
    ad = 40'h00_0000_0000;
    repeat (2) @(posedge mclk_i);
    #1 reset_i = 1'b0;
    for (int r = 0; r < 18; r++) begin
      m = rows[r][3:0];
      op(8'hBF, r[3:0], 36'hF_FFFF_FFFF);
      op({1'b1, rows[r][9:4], 1'b0}, r[3:0], 36'h0_0000_0000);
      chk("write_cycle", 36'(|m), 36'(wr));
      chk("lanes_written", 36'(m), 36'(lw));
      chk("dq_oe_n", 36'(|m), 36'(oe_n));
      op(8'hFE, r[3:0], 36'h0_0000_0000);
      chk("read data", ~spread(m), dq);
      $display("row %0d done", r);
    end
    op(8'h3F, 4'h0, 36'h0_0000_0000);
    chk("strobe flags", 36'h0_0000_0000, 36'({wr, lw}));
    op(8'hFE, 4'h0, 36'h0_0000_0000);
    chk("strobe data", 36'hF_FFFF_FFFF, dq);
    $display("strobe test done");
    reset_i = 1'b1;
    #20;
    chk("reset dq", 36'h0_0000_0000, dq);
    chk("reset flags", 36'h0_0001, 36'({wr, lw, oe_n}));
    reset_i = 1'b0;
    op(8'hFE, 4'h0, 36'h0_0000_0000);
    chk("data kept over reset", 36'hF_FFFF_FFFF, dq);
    chk("read oe after reset", 36'h0_0000_0000, 36'(oe_n));
    chk("no write after reset", 36'h0_0000_0000, 36'({wr, lw}));
    $display("reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
